// *** irs_defs.svh ***
// Constants for the index-register instruction sequencer
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH
// ==========================================
// Instruction fields
`define IRS_FUNC_LSB 9
`define IRS_FUNC_W 4
`define IRS_DESIG_LSB 7
`define IRS_DESIG_W 2
`define IRS_LOW_W 9
`define IRS_WORD_W 15
`define IRS_UP_W 6
// ==========================================
// Function and designator codes
`define IRS_F_INDEX 4'h6
`define IRS_F_STORE 4'h7
`define IRS_J_SUB 2'h1
`define IRS_J_ENTER 2'h2
`define IRS_J_CMP 2'h3
`define IRS_J_CLEAR 2'h0
`define IRS_J_STORE 2'h1
`define IRS_J_RJUMP 2'h2
// ==========================================
// Index location and reset values
`define IRS_INDEX_ADDR 9'h000
`define IRS_ZERO_WORD 15'h0000
// ==========================================
// Timing
`define IRS_ADDER_SETTLE_NS 10
`define IRS_CLK_NS 5
`define IRS_SETTLE_CYC \
    ((`IRS_ADDER_SETTLE_NS + `IRS_CLK_NS - 1) / `IRS_CLK_NS)
`endif

// *** irs_pkg.sv ***
// Types shared by the index-register instruction sequencer
package irs_pkg;
    // ==========================================
    // Phase codes, one-hot
    typedef enum logic [5:0] {
        IRS_IDLE  = 6'b000001,
        IRS_OPER  = 6'b000010,
        IRS_OWAIT = 6'b000100,
        IRS_ARITH = 6'b001000,
        IRS_STORE = 6'b010000,
        IRS_SWAIT = 6'b100000
    } irs_phase_t;

    // Memory request toward the core memory
    typedef struct packed {
        logic initiate;
        logic [8:0] addr;
        logic inhLower;
        logic inhUpper;
        logic [14:0] writeData;
    } irs_mem_req_t;

    // Instruction and program counter from fetch
    typedef struct packed {
        logic [14:0] instr;
        logic [8:0] progCount;
    } irs_instr_t;
endpackage

// *** irs_word_mux.sv ***
// Read-data merge honouring half inhibits
`timescale 1ns/10ps
module irs_word_mux (
    // Memory read data and inhibits
    input wire logic [14:0] readData,
    input wire logic inhLower,
    input wire logic inhUpper,
    input wire logic [14:0] held,
    // Merged word
    output logic [14:0] merged
);
    // Inhibited halves keep the held value
    assign merged = {inhUpper ? held[14:9] : readData[14:9],
                     inhLower ? held[8:0] : readData[8:0]};
endmodule

// *** irs_incr.sv ***
// Address-path plus zero or one incrementer
`timescale 1ns/10ps
module irs_incr (
    // Operand and select
    input wire logic [8:0] value,
    input wire logic addOne,
    // Result
    output logic [8:0] result
);
    assign result = value + {8'h00, addOne};
endmodule

// *** index_register_instruction_sequencer.sv ***
// Sequencer for index, clear-location and return-jump instructions
`timescale 1ns/10ps
`include "irs_defs.svh"
module index_register_instruction_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fetch side
    input wire logic start,
    input wire irs_pkg::irs_instr_t fetch,
    // Core memory
    output irs_pkg::irs_mem_req_t memReq,
    input wire logic memDone,
    input wire logic [14:0] memReadData,
    // Results
    output logic busy,
    output logic done,
    output logic skipFlag,
    output logic [8:0] newProgCount,
    output logic progCountLoad,
    output logic [14:0] indexValue,
    output logic incrementSelectFlag
);
    import irs_pkg::*;

    // ==========================================
    // Reset synchroniser
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ==========================================
    // Instruction decode
    logic [14:0] instr_r;
    logic [8:0] progCount_r;
    wire [3:0] func = instr_r[`IRS_FUNC_LSB +: `IRS_FUNC_W];
    wire [1:0] desig = instr_r[`IRS_DESIG_LSB +: `IRS_DESIG_W];
    wire [8:0] lowBits = instr_r[`IRS_LOW_W-1:0];
    wire isSub = func == `IRS_F_INDEX && desig == `IRS_J_SUB;
    wire isEnter = func == `IRS_F_INDEX && desig == `IRS_J_ENTER;
    wire isCmp = func == `IRS_F_INDEX && desig == `IRS_J_CMP;
    wire isStoreX = func == `IRS_F_STORE && desig == `IRS_J_STORE;
    wire isClear = func == `IRS_F_STORE && desig == `IRS_J_CLEAR;
    wire isRjump = func == `IRS_F_STORE && desig == `IRS_J_RJUMP;
    wire known = isSub | isEnter | isCmp | isStoreX | isClear | isRjump;
    wire fdec = func == `IRS_F_INDEX || func == `IRS_F_STORE;
    wire fdecStart = fetch.instr[`IRS_FUNC_LSB +: `IRS_FUNC_W] ==
                     `IRS_F_INDEX ||
                     fetch.instr[`IRS_FUNC_LSB +: `IRS_FUNC_W] ==
                     `IRS_F_STORE;
    // Return jump has no operand reference, so fetch goes straight to store
    wire fetchRjump = fetch.instr[`IRS_FUNC_LSB +: `IRS_FUNC_W] ==
                      `IRS_F_STORE &&
                      fetch.instr[`IRS_DESIG_LSB +: `IRS_DESIG_W] ==
                      `IRS_J_RJUMP;

    // ==========================================
    // Registers
    irs_phase_t phase_r;
    irs_phase_t phase_nxt;
    logic [14:0] xchg_r;   // exchange register
    logic [14:0] opnd_r;   // adder operand register
    logic [14:0] mdr_r;    // memory data register
    logic [8:0] addr_r;
    logic inhL_r;
    logic inhU_r;
    logic init_r;
    logic skip_r;
    logic incSel_r;
    logic [14:0] index_r;
    logic done_r;
    logic pcLoad_r;
    logic [8:0] pcNew_r;
    logic [1:0] settle_r;

    // ==========================================
    // Datapath helpers
    wire [14:0] diff = xchg_r + opnd_r + 15'h0001;
    wire [14:0] sum = xchg_r + opnd_r;
    wire equal = diff == `IRS_ZERO_WORD;
    wire [14:0] mergedRead;
    wire [8:0] incOut;
    // Carry out of the low nine bits reaches the upper index bits
    wire idxCarry = incSel_r && xchg_r[8:0] == 9'h1ff;

    irs_word_mux u_merge (
        .readData(memReadData),
        .inhLower(inhL_r),
        .inhUpper(inhU_r),
        .held(mdr_r),
        .merged(mergedRead)
    );

    // Incrementer feeds index increment and return-jump target
    irs_incr u_incr (
        .value(isRjump ? addr_r : xchg_r[8:0]),
        .addOne(incSel_r),
        .result(incOut)
    );

    // Clear of the increment flag: upper designator bit low, 0X, not fetching
    wire incClear = !desig[1] && !func[3] && phase_r != IRS_IDLE;

    // ==========================================
    // Phase sequencing
    wire settled = settle_r == 2'(`IRS_SETTLE_CYC);
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            IRS_IDLE: begin
                if (start && fdecStart) begin
                    phase_nxt = fetchRjump ? IRS_STORE : IRS_OPER;
                end
            end
            IRS_OPER: begin
                if (!known) begin
                    phase_nxt = IRS_IDLE;
                end else begin
                    phase_nxt = IRS_OWAIT;
                end
            end
            IRS_OWAIT: begin
                if (memDone) begin
                    phase_nxt = IRS_ARITH;
                end
            end
            IRS_ARITH: begin
                if (settled) begin
                    phase_nxt = (isCmp && equal) ? IRS_IDLE : IRS_STORE;
                end
            end
            IRS_STORE: phase_nxt = IRS_SWAIT;
            IRS_SWAIT: begin
                if (memDone) begin
                    phase_nxt = IRS_IDLE;
                end
            end
            default: phase_nxt = IRS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            phase_r <= IRS_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Settle counter gives the adder time before results are taken
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            settle_r <= 2'h0;
        end else if (phase_r != IRS_ARITH) begin
            settle_r <= 2'h0;
        end else if (!settled) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    // ==========================================
    // Instruction capture and increment flag
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            instr_r <= `IRS_ZERO_WORD;
            progCount_r <= 9'h000;
            incSel_r <= 1'b1;
        end else if (phase_r == IRS_IDLE && start && fdecStart) begin
            instr_r <= fetch.instr;
            progCount_r <= fetch.progCount;
            incSel_r <= 1'b1;
        end else if (phase_r == IRS_OPER && isStoreX && incClear) begin
            incSel_r <= 1'b0;
        end
    end

    // ==========================================
    // Memory command generation
    wire startOper = phase_r == IRS_OPER && known;
    wire startStore = phase_r == IRS_STORE;
    wire operIsIndex = isSub | isCmp | isStoreX; // index read
    wire idxWrite = isSub | isCmp | isEnter;
    wire [8:0] storeAddr = idxWrite ? `IRS_INDEX_ADDR :
                           isRjump ? lowBits : sum[8:0];
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            init_r <= 1'b0;
            addr_r <= 9'h000;
            inhL_r <= 1'b0;
            inhU_r <= 1'b0;
        end else begin
            init_r <= startOper | startStore;
            if (startOper) begin
                addr_r <= operIsIndex ? `IRS_INDEX_ADDR : lowBits;
                inhL_r <= 1'b0;
                inhU_r <= 1'b0;
            end else if (startStore) begin
                addr_r <= storeAddr;
                inhL_r <= 1'b1;
                inhU_r <= !isRjump;
            end
        end
    end

    // ==========================================
    // Register transfers
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            xchg_r <= `IRS_ZERO_WORD;
            opnd_r <= `IRS_ZERO_WORD;
            mdr_r <= `IRS_ZERO_WORD;
        end else if (startOper) begin
            mdr_r <= `IRS_ZERO_WORD;
            // Compare and subtract prepare the complemented operand
            opnd_r <= (isSub | isCmp) ? {6'h00, ~lowBits} | 15'h7e00 :
                      `IRS_ZERO_WORD;
            xchg_r <= {6'h00, lowBits};
        end else if (phase_r == IRS_OWAIT && memDone) begin
            if (isStoreX || isClear) begin
                // Low nine keep the address; memory data retained
                xchg_r <= {memReadData[14:9], xchg_r[8:0]};
                mdr_r <= memReadData;
            end else begin
                xchg_r <= memReadData;
            end
        end else if (phase_r == IRS_ARITH && settled) begin
            if (isSub) begin
                opnd_r <= diff;
            end else if (isCmp) begin
                opnd_r <= {xchg_r[14:9] + {5'h00, idxCarry}, incOut};
            end else if (isEnter) begin
                opnd_r <= xchg_r;
            end
        end else if (startStore) begin
            if (isClear) begin
                mdr_r <= `IRS_ZERO_WORD;
            end else if (isRjump) begin
                mdr_r <= {6'h00, progCount_r};
            end else if (idxWrite) begin
                mdr_r <= opnd_r;
            end
        end else if (phase_r == IRS_SWAIT && memDone) begin
            // Only halves that were not inhibited take the read word
            mdr_r <= mergedRead;
        end
    end

    // ==========================================
    // Skip, index copy, program counter
    wire finishing = phase_r == IRS_SWAIT && memDone;
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            skip_r <= 1'b0;
            index_r <= `IRS_ZERO_WORD;
            done_r <= 1'b0;
            pcLoad_r <= 1'b0;
            pcNew_r <= 9'h000;
        end else begin
            done_r <= finishing || (phase_r == IRS_ARITH && settled &&
                      isCmp && equal) || (phase_r == IRS_OPER && !known);
            pcLoad_r <= finishing && isRjump;
            if (phase_r == IRS_IDLE && start && fdecStart) begin
                skip_r <= 1'b0;
            end else if (phase_r == IRS_ARITH && settled && isCmp &&
                         equal) begin
                skip_r <= 1'b1;
            end
            if (finishing && addr_r == `IRS_INDEX_ADDR) begin
                index_r <= mdr_r;
            end
            if (finishing && isRjump) begin
                pcNew_r <= incOut;
            end
        end
    end

    // ==========================================
    // Outputs
    assign memReq.initiate = init_r;
    assign memReq.addr = addr_r;
    assign memReq.inhLower = inhL_r;
    assign memReq.inhUpper = inhU_r;
    assign memReq.writeData = mdr_r;
    assign busy = phase_r != IRS_IDLE;
    assign done = done_r;
    assign skipFlag = skip_r;
    assign newProgCount = pcNew_r;
    assign progCountLoad = pcLoad_r;
    assign indexValue = index_r;
    assign incrementSelectFlag = incSel_r;
endmodule

// *** irs_core_mem.sv ***
// Behavioural core memory with read-then-write cycles
`timescale 1ns/10ps
module irs_core_mem (
    // Clock and pacing
    input wire logic clk,
    input wire logic [2:0] lat,
    // Request and answer
    input wire irs_pkg::irs_mem_req_t memReq,
    output logic memDone,
    output logic [14:0] memReadData
);
    import irs_pkg::*;
    logic [14:0] mem [512];
    logic [8:0] a;
    logic il;
    logic iu;
    logic act = 1'b0;
    logic [2:0] n;
    logic [14:0] rd;
    initial memDone = 1'b0;
    initial memReadData = 15'h0000;
    // Read data is only valid with the done pulse
    always @(posedge clk) begin
        memDone <= 1'b0;
        memReadData <= ~memReadData;
        if (memReq.initiate) begin
            a <= memReq.addr;
            il <= memReq.inhLower;
            iu <= memReq.inhUpper;
            n <= lat;
            act <= 1'b1;
        end else if (act && n != 3'h0) begin
            n <= n - 3'h1;
        end else if (act) begin
            rd = mem[a];
            memReadData <= rd;
            memDone <= 1'b1;
            act <= 1'b0;
            // Inhibited halves take the data register, others restore
            mem[a] <= {iu ? memReq.writeData[14:9] : rd[14:9],
                il ? memReq.writeData[8:0] : rd[8:0]};
        end
    end
endmodule

// *** irs_assertions.sv ***
// Port checker for the index-register instruction sequencer
`timescale 1ns/10ps
module irs_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fetch and memory
    input wire logic start,
    input wire irs_pkg::irs_instr_t fetch,
    input wire irs_pkg::irs_mem_req_t memReq,
    input wire logic memDone,
    // Results
    input wire logic busy,
    input wire logic done,
    input wire logic skipFlag,
    input wire logic [8:0] newProgCount,
    input wire logic progCountLoad,
    input wire logic incrementSelectFlag
);
    import irs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] funcCode_r;
    logic [1:0] desig_r;
    logic [8:0] target_r;
    logic [1:0] refCount_r;
    logic memWait_r;
    wire logic [3:0] fn = fetch.instr[12:9];
    wire logic [1:0] jd = fetch.instr[8:7];
    wire logic acc = start && !busy
        && (fn == 4'h7 || (fn == 4'h6 && jd != 2'h0));
    wire logic rjump = funcCode_r == 4'h7 && desig_r == 2'h2;
    // Captured at acceptance so later checks know the instruction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            funcCode_r <= 4'h0;
            desig_r <= 2'h0;
            target_r <= 9'h000;
            refCount_r <= 2'h0;
            memWait_r <= 1'b0;
        end else begin
            if (acc) begin
                funcCode_r <= fn;
                desig_r <= jd;
                target_r <= fetch.instr[8:0];
                refCount_r <= 2'h0;
            end else if (memReq.initiate) begin
                refCount_r <= refCount_r + 2'h1;
            end
            if (memReq.initiate) begin
                memWait_r <= 1'b1;
            end else if (memDone) begin
                memWait_r <= 1'b0;
            end
        end
    end
    sequence sAccept;
        acc;
    endsequence
    sequence sSecondRef;
        memReq.initiate && refCount_r == 2'h1;
    endsequence
    a_initiate_after_start: assert property (sAccept |-> ##2 memReq.initiate) else $error("no memory start after accept");
    a_busy_after_start: assert property (sAccept |=> busy [*2]) else $error("busy missing after accept");
    a_done_single_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_skip_clear_start: assert property (sAccept |=> !skipFlag) else $error("skip not cleared at start");
    a_inc_preset_start: assert property (sAccept |=> incrementSelectFlag) else $error("increment not preset");
    a_inc_kept_high: assert property (busy && desig_r[1] |-> incrementSelectFlag) else $error("increment cleared wrongly");
    a_no_overlap: assert property (memWait_r |-> !memReq.initiate) else $error("memory restarted while busy");
    a_index_loc_addr: assert property (memReq.initiate && funcCode_r == 4'h6 && (refCount_r == 2'h1 || desig_r != 2'h2) |-> memReq.addr == 9'h000) else $error("index reference not at zero");
    a_read_no_inhibit: assert property (memReq.initiate && refCount_r == 2'h0 && !rjump |-> !memReq.inhLower && !memReq.inhUpper) else $error("operand read inhibited");
    a_write_both_inh: assert property (sSecondRef |-> memReq.inhLower && memReq.inhUpper) else $error("store phase not inhibited");
    a_store_target: assert property (sSecondRef and funcCode_r == 4'h7 |-> memReq.addr == target_r) else $error("store address wrong");
    a_rjump_lower: assert property (memReq.initiate && rjump |-> memReq.inhLower && !memReq.inhUpper && memReq.addr == target_r) else $error("return jump inhibit wrong");
    a_pc_target: assert property (progCountLoad |-> rjump && newProgCount == target_r + 9'h001) else $error("new program count wrong");
endmodule
bind index_register_instruction_sequencer irs_assertions irs_assertions_i (
    .clk(clk), .reset_n(reset_n), .start(start), .fetch(fetch),
    .memReq(memReq), .memDone(memDone), .busy(busy), .done(done),
    .skipFlag(skipFlag), .newProgCount(newProgCount),
    .progCountLoad(progCountLoad),
    .incrementSelectFlag(incrementSelectFlag));

// *** index_register_instruction_sequencer_tb_top.sv ***
// Self-checking bench for the index-register instruction sequencer
`timescale 1ns/10ps
module index_register_instruction_sequencer_tb_top;
    import irs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    irs_instr_t fetch = '0;
    irs_mem_req_t memReq;
    logic memDone, busy, done, skipFlag, progCountLoad, incSel;
    logic [14:0] memReadData, indexValue;
    logic [8:0] newProgCount, pcSeen;
    logic [2:0] lat = 3'h0;
    logic [31:0] seed = 32'h00017ef1;
    int err_count = 0;
    int tests_run = 0;
    int nInit = 0;
    int model [512];
    always #2.5 clk = ~clk;
    index_register_instruction_sequencer
        index_register_instruction_sequencer_i (.clk(clk),
        .reset_n(reset_n), .start(start), .fetch(fetch), .memReq(memReq),
        .memDone(memDone), .memReadData(memReadData), .busy(busy),
        .done(done), .skipFlag(skipFlag), .newProgCount(newProgCount),
        .progCountLoad(progCountLoad), .indexValue(indexValue),
        .incrementSelectFlag(incSel));
    irs_core_mem irs_core_mem_i (.clk(clk), .lat(lat), .memReq(memReq),
        .memDone(memDone), .memReadData(memReadData));
    always @(posedge clk) begin
        if (memReq.initiate === 1'b1) nInit++;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", what, e, g);
            err_count++;
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Start is held a second cycle with junk, which busy must refuse
    task automatic run(input logic [3:0] fn, input logic [8:0] y,
        input logic [8:0] pc);
        int k;
        int ni;
        logic [31:0] r;
        k = 0;
        // Compare-equal skips its write-back, return jump has no operand
        ni = 2;
        if (fn == 4'h6 && y[8:7] == 2'h0) ni = 0;
        if (fn == 4'h7 && y[8:7] == 2'h2) ni = 1;
        if (fn == 4'h6 && y[8:7] == 2'h3 && model[0] == y) ni = 1;
        r = xs();
        nInit = 0;
        @(posedge clk);
        start <= 1'b1;
        fetch <= '{instr: {2'b00, fn, y}, progCount: pc};
        @(posedge clk);
        fetch <= '{instr: r[14:0], progCount: r[23:15]};
        @(posedge clk);
        start <= 1'b0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        chk("done", 1, done);
        chk("initiates", ni, nInit);
        chk("pc load", fn == 4'h7 && y[8:7] == 2'h2, progCountLoad);
        pcSeen = newProgCount;
        $display("test f%0h j%0h finished", fn, y[8:7]);
    endtask
    initial begin
        int y, w, d;
        logic [8:0] pc;
        for (int i = 0; i < 512; i++) begin
            w = xs() & 32'h7fff;
            irs_core_mem_i.mem[i] = w[14:0];
            model[i] = w;
        end
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int r = 0; r < 8; r++) begin
            w = xs();
            lat <= w[2:0];
            // Positive index well above any operand keeps sums simple
            y = {2'b10, w[9:3]};
            model[y] = (model[y] | 32'h0200) & 32'h3fff;
            irs_core_mem_i.mem[y] = model[y][14:0];
            run(4'h6, y[8:0], 9'h000);
            model[0] = model[y];
            chk("index enter", model[0], indexValue);
            y = {2'b01, w[16:10]};
            run(4'h6, y[8:0], 9'h000);
            model[0] = model[0] - y;
            chk("index sub", model[0], indexValue);
            chk("skip sub", 0, skipFlag);
            y = {2'b01, w[23:17]};
            run(4'h7, y[8:0], 9'h000);
            model[y] = model[0];
            chk("store", model[y], irs_core_mem_i.mem[y]);
            chk("inc clear", 0, incSel);
            y = {2'b00, w[30:24]} | 1;
            run(4'h7, y[8:0], 9'h000);
            chk("clear", 0, irs_core_mem_i.mem[y]);
            // Even rounds load a matching index first
            y = {2'b11, w[9:3]};
            if (r % 2 == 0) begin
                d = {2'b10, w[16:10]};
                irs_core_mem_i.mem[d] = y[14:0];
                model[d] = y;
                run(4'h6, d[8:0], 9'h000);
                model[0] = y;
            end
            run(4'h6, y[8:0], 9'h000);
            chk("skip cmp", model[0] == y, skipFlag);
            if (model[0] != y) model[0] = (model[0] + 1) & 32'h7fff;
            chk("index cmp", model[0], indexValue);
            chk("inc kept", 1, incSel);
            chk("loc zero", model[0], irs_core_mem_i.mem[0]);
            y = (r == 0) ? 32'h17f : {2'b10, w[29:23]};
            pc = w[8:0];
            model[y] = (model[y] & 32'h7e00) | pc;
            run(4'h7, y[8:0], pc);
            chk("saved pc", model[y], irs_core_mem_i.mem[y]);
            chk("new pc", (y + 1) & 32'h1ff, pcSeen);
        end
        // Undefined designator ends at once and leaves the index alone
        run(4'h6, 9'h015, 9'h000);
        chk("undefined index", model[0], indexValue);
        // Unlisted function code must start nothing
        nInit = 0;
        @(posedge clk);
        start <= 1'b1;
        fetch <= '{instr: 15'h0a00, progCount: 9'h000};
        @(posedge clk);
        start <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("refused busy", 0, busy);
        chk("refused mem", 0, nInit);
        $display("test refusal finished");
        wrap_up();
    end
    // Whole run is around a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule
